// File: rtl/xpc_config_regs.sv
// Write-only configuration register bank of the crosspoint switch, serial target port
`timescale 1ns/1ps

// Overview of operation
// R01: The target address is 0x06 with strap low setting bit 6 and strap high setting bit 7.
// R02: Each write carries a register address byte then a data byte after the target address.
// R03: Each routing register holds the odd output select in 3:0 and the even one in 7:4.
// R04: A select of 0000 means off and 0001 to 1000 pick inputs one to eight.
// R05: Any number of outputs may pick the same input, each output taking at most one.
// R06: Routing registers for output pairs 1/2, 3/4, 5/6 sit at 0x00, 0x01, 0x02.
// R07: Register 0x03 holds one clamp (1) or bias (0) bit per input, bit n-1 for input n.
// R08: Register 0x04 holds gain bits 5:0, 0 for 6dB and 1 for 0dB, bits 7:6 unused.
// R09: After reset every field is zero: outputs off, inputs biased, gain 6dB.
// R10: Writes to undefined register addresses are acknowledged and change nothing.
// R11: An output with select 0000 is powered down and placed in high impedance.
// R12: Only writes are supported and a read never drives register contents on the data line.
// R13: The device pulls data low in the acknowledge pulse after each byte it receives; the code leaves any byte after the data byte unacknowledged.
// R14: The first byte after a start is the target address.
// R15: A register updates once its data byte is received and acknowledged; other targets are ignored.
// R16: The controller closes each register write with a stop before another transfer; the testbench also cuts one write short with a repeated start.
module xpc_config_regs
    import xpc_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   scl_i,
    input  wire logic                   sda_i,
    output logic                        sda_o,
    output logic                        sda_oe_n_o,
    input  wire logic                   address_strap_low_i,
    input  wire logic                   address_strap_high_i,
    output logic [NUM_OUTPUTS-1:0][3:0] output_select_o,
    output logic [NUM_OUTPUTS-1:0]      output_power_down_o,
    output logic [NUM_OUTPUTS-1:0]      output_gain_0db_o,
    output logic [NUM_INPUTS-1:0]       input_clamp_mode_o,
    output xpc_ctrl_type                ctrl_o
);

    // ------------------------------------------------------------------
    // Decode functions
    // ------------------------------------------------------------------
    // One-hot input enable for a select nibble; values above eight route nothing
    function automatic logic [NUM_INPUTS-1:0] sel_onehot(input logic [3:0] sel);
        logic [NUM_INPUTS-1:0] oh;
        oh = '0;
        if (sel != SEL_OFF && sel <= SEL_MAX) begin
            oh[3'(sel - 4'h1)] = 1'b1; // R04
        end
        return oh;
    endfunction : sel_onehot

    // Whether a register address is one of the five defined ones
    function automatic logic reg_defined(input logic [7:0] a);
        return (a <= REG_GAIN);
    endfunction : reg_defined

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic scl_s;
    logic sda_s;
    logic strap_lo_s;
    logic strap_hi_s;

    xpc_sync u_sync_scl (.clk_i(clk_i), .rst_i(rst_i), .pin_i(scl_i), .pin_o(scl_s));
    xpc_sync u_sync_sda (.clk_i(clk_i), .rst_i(rst_i), .pin_i(sda_i), .pin_o(sda_s));
    xpc_sync u_sync_sl  (.clk_i(clk_i), .rst_i(rst_i), .pin_i(address_strap_low_i),
                         .pin_o(strap_lo_s));
    xpc_sync u_sync_sh  (.clk_i(clk_i), .rst_i(rst_i), .pin_i(address_strap_high_i),
                         .pin_o(strap_hi_s));

    // ------------------------------------------------------------------
    // Edge and condition detection
    // ------------------------------------------------------------------
    logic scl_d_ff;
    logic sda_d_ff;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
        end
    end

    assign scl_rise  = scl_s & ~scl_d_ff;
    assign scl_fall  = ~scl_s & scl_d_ff;
    assign start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    assign stop_det  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

    // ------------------------------------------------------------------
    // Target address from straps
    // ------------------------------------------------------------------
    logic [7:0] own_addr;

    always_comb begin
        own_addr                 = TGT_ADDR_BASE;
        own_addr[STRAP_LOW_BIT]  = strap_lo_s; // R01
        own_addr[STRAP_HIGH_BIT] = strap_hi_s; // R01
    end

    // ------------------------------------------------------------------
    // Byte receiver and transfer state
    // ------------------------------------------------------------------
    xpc_state_type state_ff;
    xpc_state_type nxt_state;
    logic [7:0]    shift_ff;
    logic [3:0]    bit_cnt_ff;
    logic          ack_ff;
    xpc_wr_type    wr_ff;
    logic          wr_go_ff;
    logic          byte_done;
    logic [7:0]    rx_byte;

    // Byte is complete on the eighth rising clock edge
    assign byte_done = scl_rise && (bit_cnt_ff == BIT_CNT_ACK - 4'h1);
    assign rx_byte   = {shift_ff[6:0], sda_s};

    // Bit counter and shifter; a start restarts framing anywhere
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            shift_ff   <= 8'h00;
            bit_cnt_ff <= 4'h0;
        end else if (start_det || stop_det) begin
            bit_cnt_ff <= 4'h0; // R14
        end else if (scl_rise && bit_cnt_ff <= BIT_CNT_ACK) begin
            shift_ff   <= rx_byte;
            bit_cnt_ff <= bit_cnt_ff + 4'h1; // Ninth rise is the acknowledge pulse
        end else if (scl_fall && bit_cnt_ff == BIT_CNT_ACK + 4'h1) begin
            bit_cnt_ff <= 4'h0; // Acknowledge slot finished
        end
    end

    // Next state on each completed byte
    always_comb begin
        nxt_state = state_ff;
        if (stop_det) begin
            nxt_state = ST_IDLE;
        end else if (start_det) begin
            nxt_state = ST_ADDR; // R14
        end else if (byte_done) begin
            case (state_ff)
                ST_ADDR: begin
                    // Read bit set or foreign address: stay silent, R12 R15
                    if (rx_byte == own_addr) nxt_state = ST_REG;
                    else                     nxt_state = ST_IGNORE;
                end
                ST_REG:    nxt_state = ST_DATA; // R02
                ST_DATA:   nxt_state = ST_IGNORE;
                ST_IGNORE: nxt_state = ST_IGNORE;
                ST_IDLE:   nxt_state = ST_IDLE;
                default:   nxt_state = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) state_ff <= ST_IDLE;
        else       state_ff <= nxt_state;
    end

    // Acknowledge pending from the eighth rise until the eighth clock falls
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else if (start_det || stop_det) begin
            ack_ff <= 1'b0;
        end else if (byte_done && (state_ff == ST_REG || state_ff == ST_DATA ||
                     (state_ff == ST_ADDR && rx_byte == own_addr))) begin
            ack_ff <= 1'b1; // R13
        end else if (scl_fall && bit_cnt_ff == BIT_CNT_ACK) begin
            ack_ff <= 1'b0;
        end
    end

    // Drive low only after the eighth clock has fallen, so the hold is kept
    logic ack_drive_ff;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_drive_ff <= 1'b0;
        end else if (start_det || stop_det) begin
            ack_drive_ff <= 1'b0;
        end else if (scl_fall && bit_cnt_ff == BIT_CNT_ACK + 4'h1) begin
            ack_drive_ff <= 1'b0; // Ninth clock has fallen, let the line go
        end else if (scl_fall && ack_ff && bit_cnt_ff == BIT_CNT_ACK) begin
            ack_drive_ff <= 1'b1; // R13
        end
    end

    // Open drain: only ever pulls low, never returns register data, R12
    assign sda_o      = 1'b0;
    assign sda_oe_n_o = ~ack_drive_ff; // R12 R13

    // Register address and data capture; write fires at end of acknowledge
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ff    <= '0;
            wr_go_ff <= 1'b0;
        end else begin
            wr_go_ff <= 1'b0;
            if (byte_done && state_ff == ST_REG) begin
                wr_ff.addr <= rx_byte; // R02
            end
            if (byte_done && state_ff == ST_DATA) begin
                wr_ff.data <= rx_byte; // R02
            end
            if (scl_fall && ack_drive_ff && state_ff == ST_IGNORE) begin
                wr_go_ff <= 1'b1; // R15
            end
        end
    end

    // ------------------------------------------------------------------
    // Register bank
    // ------------------------------------------------------------------
    logic [NUM_ROUTE_REGS-1:0][7:0] route_ff;
    logic [7:0]                     clamp_ff;
    logic [7:0]                     gain_ff;

    // Routing registers indexed by address; undefined addresses fall through, R10
    genvar gr;
    generate
        for (gr = 0; gr < NUM_ROUTE_REGS; gr++) begin : g_route
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    route_ff[gr] <= REG_RESET_VAL; // R09
                end else if (wr_go_ff && wr_ff.addr == REG_ROUTE_1_2 + 8'(gr)) begin
                    route_ff[gr] <= wr_ff.data; // R06 R15
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            clamp_ff <= REG_RESET_VAL; // R09
            gain_ff  <= REG_RESET_VAL; // R09
        end else if (wr_go_ff && reg_defined(wr_ff.addr)) begin
            if (wr_ff.addr == REG_CLAMP_BIAS) clamp_ff <= wr_ff.data; // R07
            if (wr_ff.addr == REG_GAIN)       gain_ff  <= wr_ff.data & GAIN_USED_MASK; // R08
        end
    end

    // ------------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------------
    // Each output picks one nibble, so it can never take two inputs
    genvar go;
    generate
        for (go = 0; go < NUM_OUTPUTS; go++) begin : g_out
            localparam int LSB = (go % 2 == 0) ? SEL_ODD_LSB : SEL_EVEN_LSB;
            assign output_select_o[go]     = route_ff[go/2][LSB +: SEL_WIDTH]; // R03 R05
            assign output_power_down_o[go] = (output_select_o[go] == SEL_OFF); // R11
            assign ctrl_o.route[go]        = sel_onehot(output_select_o[go]); // R04 R05
        end
    endgenerate

    assign output_gain_0db_o   = gain_ff[NUM_OUTPUTS-1:0]; // R08
    assign input_clamp_mode_o  = clamp_ff; // R07
    assign ctrl_o.power_down   = output_power_down_o;
    assign ctrl_o.clamp_mode   = input_clamp_mode_o;
    assign ctrl_o.gain_0db     = output_gain_0db_o;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_off_powers_down;
        @(posedge clk_i) disable iff (rst_i)
        (output_select_o[0] == SEL_OFF) |-> (output_power_down_o[0] && ctrl_o.route[0] == '0);
    endproperty
    a_off_powers_down: assert property (p_off_powers_down) // R11
        else $error("Output one off but not powered down");

    property p_ack_only_low;
        @(posedge clk_i) disable iff (rst_i)
        !sda_oe_n_o |-> (sda_o == 1'b0);
    endproperty
    a_ack_only_low: assert property (p_ack_only_low) // R12
        else $error("Data line driven high");

    property p_ack_after_byte;
        @(posedge clk_i) disable iff (rst_i)
        $fell(sda_oe_n_o) |-> $past(ack_ff) && $past(scl_fall);
    endproperty
    a_ack_after_byte: assert property (p_ack_after_byte) // R13
        else $error("Acknowledge without received byte");

    property p_no_ack_idle;
        @(posedge clk_i) disable iff (rst_i)
        (state_ff == ST_IDLE) |-> sda_oe_n_o;
    endproperty
    a_no_ack_idle: assert property (p_no_ack_idle) // R14
        else $error("Acknowledge while not addressed");

    property p_gain_write;
        @(posedge clk_i) disable iff (rst_i)
        (wr_go_ff && wr_ff.addr == REG_GAIN) |=> (gain_ff == ($past(wr_ff.data) & GAIN_USED_MASK));
    endproperty
    a_gain_write: assert property (p_gain_write) // R08
        else $error("Gain register not updated");

    property p_clamp_write;
        @(posedge clk_i) disable iff (rst_i)
        (wr_go_ff && wr_ff.addr == REG_CLAMP_BIAS) |=> (input_clamp_mode_o == $past(wr_ff.data));
    endproperty
    a_clamp_write: assert property (p_clamp_write) // R07
        else $error("Clamp register not updated");

    property p_undef_no_effect;
        @(posedge clk_i) disable iff (rst_i)
        (wr_go_ff && !reg_defined(wr_ff.addr)) |=> $stable(ctrl_o);
    endproperty
    a_undef_no_effect: assert property (p_undef_no_effect) // R10
        else $error("Undefined address changed state");

    property p_route_pair;
        @(posedge clk_i) disable iff (rst_i)
        (wr_go_ff && wr_ff.addr == REG_ROUTE_3_4) |=>
            (output_select_o[2] == $past(wr_ff.data[3:0]) &&
             output_select_o[3] == $past(wr_ff.data[7:4]));
    endproperty
    a_route_pair: assert property (p_route_pair) // R03
        else $error("Routing nibbles misplaced");

    property p_write_needs_addressing;
        @(posedge clk_i) disable iff (rst_i)
        $rose(wr_go_ff) |-> (state_ff == ST_IGNORE);
    endproperty
    a_write_needs_addressing: assert property (p_write_needs_addressing) // R15
        else $error("Write without data byte");

endmodule : xpc_config_regs

// File: shared/xpc_pkg.sv
// Package for the crosspoint configuration register bank: map, fields, counts and transfer state
package xpc_pkg;

    // ------------------------------------------------------------------
    // Target address
    // ------------------------------------------------------------------
    localparam logic [7:0] TGT_ADDR_BASE   = 8'h06;
    localparam int         STRAP_LOW_BIT   = 6;
    localparam int         STRAP_HIGH_BIT  = 7;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_ROUTE_1_2   = 8'h00;
    localparam logic [7:0] REG_ROUTE_3_4   = 8'h01;
    localparam logic [7:0] REG_ROUTE_5_6   = 8'h02;
    localparam logic [7:0] REG_CLAMP_BIAS  = 8'h03;
    localparam logic [7:0] REG_GAIN        = 8'h04;
    localparam logic [7:0] REG_RESET_VAL   = 8'h00;
    localparam logic [7:0] GAIN_USED_MASK  = 8'h3F;

    // ------------------------------------------------------------------
    // Fields and counts
    // ------------------------------------------------------------------
    localparam int         NUM_INPUTS      = 8;
    localparam int         NUM_OUTPUTS     = 6;
    localparam int         NUM_ROUTE_REGS  = 3;
    localparam int         SEL_WIDTH       = 4;
    localparam int         SEL_ODD_LSB     = 0;
    localparam int         SEL_EVEN_LSB    = 4;
    localparam logic [3:0] SEL_OFF         = 4'h0;
    localparam logic [3:0] SEL_MAX         = 4'h8;
    localparam int         BITS_PER_BYTE   = 8;
    localparam logic [3:0] BIT_CNT_ACK     = 4'h8;

    // ------------------------------------------------------------------
    // Transfer state and carried structures
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_ADDR    = 3'b001,
        ST_REG     = 3'b010,
        ST_DATA    = 3'b011,
        ST_IGNORE  = 3'b100
    } xpc_state_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } xpc_wr_type;

    typedef struct packed {
        logic [NUM_OUTPUTS-1:0][NUM_INPUTS-1:0] route;
        logic [NUM_OUTPUTS-1:0]                 power_down;
        logic [NUM_INPUTS-1:0]                  clamp_mode;
        logic [NUM_OUTPUTS-1:0]                 gain_0db;
    } xpc_ctrl_type;

endpackage : xpc_pkg

// File: rtl/xpc_sync.sv
// Two-stage synchroniser for the serial clock and data pins
`timescale 1ns/1ps

module xpc_sync
    import xpc_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic pin_i,
    output logic      pin_o
);

    logic meta_ff;
    logic sync_ff;

    // ------------------------------------------------------------------
    // Stages
    // ------------------------------------------------------------------
    // Idle bus is high, so reset to high to avoid a false start on release
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
        end else begin
            meta_ff <= pin_i;
            sync_ff <= meta_ff;
        end
    end

    assign pin_o = sync_ff;

endmodule : xpc_sync

// File: verif/xpc_i2c_ctrl.sv
// Serial bus controller model that programs the crosspoint register bank
`timescale 1ns/1ps

module xpc_i2c_ctrl (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    // ------------------------------------------------------------------
    // Bus phases, 800 ns clock period: 5 cycles low, 3 high
    // ------------------------------------------------------------------
    // Idle bus: clock driven high, data left to the pull-up
    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    // Start, also usable as a repeated start; the target byte must follow
    task automatic start_c();
        tick(4);
        sda_low_o <= 1'b0;
        tick(1);
        scl_o     <= 1'b1;
        tick(4);
        sda_low_o <= 1'b1;
        tick(4);
        scl_o     <= 1'b0;
    endtask : start_c

    // Stop closing each full write, then the bus rests before the next
    task automatic stop_c();
        tick(4);
        sda_low_o <= 1'b1;
        tick(1);
        scl_o     <= 1'b1;
        tick(4);
        sda_low_o <= 1'b0;
        tick(8);
    endtask : stop_c

    // Eight bits MSB first, then the line is released for the acknowledge
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            tick(4);
            sda_low_o <= !b[i];
            tick(1);
            scl_o     <= 1'b1;
            tick(3);
            scl_o     <= 1'b0;
        end
        tick(4);
        sda_low_o <= 1'b0;
        tick(1);
        scl_o     <= 1'b1;
        tick(1);
        // Sampled mid-pulse, away from the edge where the device updates
        @(negedge clk_i) ack = sda_i;
        tick(2);
        scl_o     <= 1'b0;
    endtask : send_byte
endmodule : xpc_i2c_ctrl

// File: verif/tb.sv
// Self-checking testbench for the crosspoint configuration register bank
`timescale 1ns/1ps

module tb
    import xpc_pkg::*;
;
    logic                        clk_i = 1'b0;
    logic                        rst_i = 1'b1;
    logic                        strap_low = 1'b0;
    logic                        strap_high = 1'b0;
    logic                        scl, m_low, sda_o, sda_oe_n, sda_w, ack;
    logic [NUM_OUTPUTS-1:0][3:0] sel;
    logic [NUM_OUTPUTS-1:0]      pd, gain;
    logic [NUM_INPUTS-1:0]       clamp;
    xpc_ctrl_type                ctrl_q;
    logic [7:0]                  e_reg [0:4];
    logic [7:0]                  ta;
    logic                        low_seen = 1'b0;
    logic                        watch = 1'b0;
    int                          n_mismatch = 0;
    int                          check_count = 0;
    int                          cycles = 0;

    // ------------------------------------------------------------------
    // Clock, wired-and data line, instances
    // ------------------------------------------------------------------
    always #50 clk_i = ~clk_i;
    assign sda_w = !(m_low || (!sda_oe_n && !sda_o));

    xpc_config_regs dut (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .address_strap_low_i(strap_low),
        .address_strap_high_i(strap_high), .output_select_o(sel), .output_power_down_o(pd),
        .output_gain_0db_o(gain), .input_clamp_mode_o(clamp), .ctrl_o(ctrl_q));
    xpc_i2c_ctrl host (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_low_o(m_low));

    // Any pull on the data line while the device should stay silent
    always @(posedge clk_i) if (watch && !sda_w) low_seen <= 1'b1;

    // Hang guard: a full run needs about 8.5k cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            n_mismatch++;
            summarize();
        end
    end

    // ------------------------------------------------------------------
    // Compare tasks and verdict
    // ------------------------------------------------------------------
    task automatic chk_ack(input logic got, input logic exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s ack %b expected %b", $time, what, got, exp);
        end
    endtask : chk_ack

    task automatic chk_vec(input logic [95:0] got, input logic [95:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s %h expected %h", $time, what, got, exp);
        end
    endtask : chk_vec

    // Expected outputs rebuilt from the shadow copy of the five registers
    task automatic check_all();
        xpc_ctrl_type                ec;
        logic [NUM_OUTPUTS-1:0][3:0] es;
        ec = '0;
        for (int k = 0; k < NUM_OUTPUTS; k++) begin
            es[k] = e_reg[k/2][4*(k%2) +: 4];
            ec.power_down[k] = (es[k] == SEL_OFF);
            if (es[k] != SEL_OFF && es[k] <= SEL_MAX) ec.route[k][es[k]-1] = 1'b1;
            ec.gain_0db[k] = e_reg[4][k];
        end
        ec.clamp_mode = e_reg[3];
        chk_vec(96'(sel), 96'(es), "select");
        chk_vec(96'(pd), 96'(ec.power_down), "power down");
        chk_vec(96'(gain), 96'(ec.gain_0db), "gain");
        chk_vec(96'(clamp), 96'(ec.clamp_mode), "clamp");
        chk_vec(96'(ctrl_q), 96'(ec), "control struct");
    endtask : check_all

    // One register write; e_ack is the expected line level in the target, register and data ack slots
    task automatic wr(input logic [7:0] tgt, input logic [7:0] ra, input logic [7:0] d,
                      input logic e_ack, input logic extra = 1'b0);
        host.start_c();
        host.send_byte(tgt, ack);
        chk_ack(ack, e_ack, "target");
        host.send_byte(ra, ack);
        chk_ack(ack, e_ack, "register");
        host.send_byte(d, ack);
        chk_ack(ack, e_ack, "data");
        if (extra) begin
            host.send_byte(8'h34, ack);
            chk_ack(ack, 1'b1, "surplus byte");
        end
        host.stop_c();
        if (!e_ack && ra <= REG_GAIN)
            e_reg[ra[2:0]] = (ra == REG_GAIN) ? (d & GAIN_USED_MASK) : d;
        check_all();
    endtask : wr

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        for (int r = 0; r < 5; r++) e_reg[r] = REG_RESET_VAL;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        check_all();
        // Each strap setting, with a neighbouring address left unanswered
        for (int s = 0; s < 4; s++) begin
            strap_low  <= s[0];
            strap_high <= s[1];
            repeat (4) @(posedge clk_i);
            wr(TGT_ADDR_BASE | 8'(s << 6), REG_ROUTE_1_2, 8'(8'h10 * s + 8'h01), 1'b0);
            wr(TGT_ADDR_BASE | 8'(((s + 1) % 4) << 6), REG_ROUTE_1_2, 8'h77, 1'b1);
        end
        ta = TGT_ADDR_BASE | 8'hC0;
        for (int v = 0; v <= 8; v++) wr(ta, REG_ROUTE_3_4, {4'(v), 4'(8 - v)}, 1'b0);
        wr(ta, REG_ROUTE_5_6, 8'hF9, 1'b0);
        // One input feeding all six outputs, then distinct picks per register
        for (int r = 0; r < 3; r++) wr(ta, 8'(r), 8'h55, 1'b0);
        for (int r = 0; r < 3; r++) wr(ta, 8'(r), 8'(8'h21 + 8'h22 * r), 1'b0);
        wr(ta, REG_CLAMP_BIAS, 8'hA5, 1'b0);
        wr(ta, REG_GAIN, 8'hFF, 1'b0);
        wr(ta, REG_GAIN, 8'hC2, 1'b0);
        wr(ta, 8'h05, 8'hFF, 1'b0);
        wr(ta, 8'hFF, 8'h00, 1'b0);
        wr(ta, REG_ROUTE_1_2, 8'h12, 1'b0, 1'b1);
        // Lone register byte writes nothing
        host.start_c();
        host.send_byte(ta, ack);
        host.send_byte(REG_GAIN, ack);
        host.stop_c();
        check_all();
        // Write cut short after its register byte by a repeated start
        host.start_c();
        host.send_byte(ta, ack);
        host.send_byte(REG_CLAMP_BIAS, ack);
        wr(ta, REG_GAIN, 8'h01, 1'b0);
        // Read request: no acknowledge and the line never pulled
        host.start_c();
        host.send_byte(ta | 8'h01, ack);
        chk_ack(ack, 1'b1, "read target");
        watch <= 1'b1;
        host.send_byte(8'hFF, ack);
        watch <= 1'b0;
        host.stop_c();
        chk_ack(low_seen, 1'b0, "read drive");
        // Reset in mid-run brings every field back to zero
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int r = 0; r < 5; r++) e_reg[r] = REG_RESET_VAL;
        repeat (4) @(posedge clk_i);
        check_all();
        wr(ta, REG_GAIN, 8'h3F, 1'b0);
        summarize();
    end
endmodule : tb
